//--- hw/pbs_pkg.sv
// Purpose: Shared constants and types for the pipelined burst SRAM port
// Assumes: One clock domain; host logic runs on the same clock
// Notes:   Data lanes are nine bits wide, lane i at bits [9*i+8:9*i]

package pbs_pkg;

  // ************************************************************
  // Geometry
  // ************************************************************
  localparam int PBS_AW     = 17;
  localparam int PBS_DW     = 36;
  localparam int PBS_LANES  = 4;
  localparam int PBS_LANE_W = 9;
  localparam int PBS_DEPTH  = 1 << PBS_AW;
  localparam int PBS_LO_W   = 2;

  localparam logic [PBS_LO_W-1:0] PBS_CNT_START = 2'h0;
  localparam logic [PBS_LO_W-1:0] PBS_CNT_STEP  = 2'h1;
  localparam logic [PBS_LO_W-1:0] PBS_CNT_LAST  = 2'h3;
  localparam logic [PBS_DW-1:0]   PBS_DQ_RESET  = 36'h0_0000_0000;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    PBS_IDLE,
    PBS_RD_BURST,
    PBS_WR_BURST
  } pbs_burst_e;

  typedef struct packed {
    logic                 vld;
    logic                 wr;
    logic [PBS_AW-1:0]    addr;
    logic [PBS_LANES-1:0] bwn;
  } pbs_stage_s;

  localparam pbs_stage_s PBS_STAGE_IDLE = '{vld: 1'b0, wr: 1'b0,
                                            addr: 17'h0_0000, bwn: 4'hf};

endpackage

//--- hw/pbs_sram_port.sv
// Purpose: Pipelined burst SRAM port, 128K x 36, two-cycle data pipeline
// Assumes: Host drives all inputs from logic on core_clk; no synchronisers
// Notes:   Output drive enable is taken on the edge that loads read data

module pbs_sram_port
  import pbs_pkg::*;
(
  input  wire logic                 core_clk,            // Clock
  input  wire logic                 rst_n,               // Async reset, active low
  input  wire logic [PBS_AW-1:0]    addr,                // Word address
  input  wire logic                 read_write,          // High read, low write
  input  wire logic                 advance_or_load,     // High advance, low load
  input  wire logic                 clock_gate_n,        // Low lets the edge act
  input  wire logic [PBS_LANES-1:0] byte_lane_write_n,   // Lane write selects, low
  input  wire logic                 chip_select_a_n,     // Chip enable, low
  input  wire logic                 chip_select_b,       // Chip enable, high
  input  wire logic                 chip_select_c_n,     // Chip enable, low
  input  wire logic                 burst_order_select,  // High interleaved
  input  wire logic                 out_drive_n,         // Output drive enable, low
  input  wire logic [PBS_DW-1:0]    dq_in,               // Data bus level
  output logic      [PBS_DW-1:0]    dq_out,              // Read data
  output logic                      dq_oe                // High while driving bus
);

  // ************************************************************
  // Functions
  // ************************************************************
  function automatic logic [PBS_LO_W-1:0] burst_lo(
    input logic [PBS_LO_W-1:0] base,
    input logic [PBS_LO_W-1:0] cnt,
    input logic                order
  );
    burst_lo = order ? (base ^ cnt) : PBS_LO_W'(base + cnt);
  endfunction

  function automatic logic [PBS_DW-1:0] lane_merge(
    input logic [PBS_DW-1:0]    old_w,
    input logic [PBS_DW-1:0]    new_w,
    input logic [PBS_LANES-1:0] bwn
  );
    lane_merge = old_w;
    for (int i = 0; i < PBS_LANES; i++) begin
      if (!bwn[i]) begin
        lane_merge[i*PBS_LANE_W +: PBS_LANE_W] = new_w[i*PBS_LANE_W +: PBS_LANE_W];
      end
    end
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  logic [PBS_DW-1:0]        mem_q [PBS_DEPTH];
  pbs_burst_e               burst_q;
  pbs_burst_e               burst_d;
  logic [PBS_LO_W-1:0]      base_q;
  logic [PBS_LO_W-1:0]      base_d;
  logic [PBS_LO_W-1:0]      cnt_q;
  logic [PBS_LO_W-1:0]      cnt_d;
  logic [PBS_AW-1:PBS_LO_W] hi_q;
  logic [PBS_AW-1:PBS_LO_W] hi_d;
  pbs_stage_s               s1_q;
  pbs_stage_s               s1_d;
  pbs_stage_s               s2_q;
  pbs_stage_s               s2_d;
  logic [PBS_DW-1:0]        dq_out_q;
  logic [PBS_DW-1:0]        dq_out_d;
  logic                     dq_oe_q;
  logic                     dq_oe_d;

  // ************************************************************
  // Command decode
  // ************************************************************
  wire                  en       = !clock_gate_n;
  wire                  sel      = !chip_select_a_n && !chip_select_c_n && chip_select_b;
  wire                  ld       = !advance_or_load;
  wire                  ld_go    = ld && sel;
  wire                  desel    = ld && !sel;
  wire                  adv_go   = advance_or_load && (burst_q != PBS_IDLE);
  wire [PBS_LO_W-1:0]   cnt_nx   = PBS_LO_W'(cnt_q + PBS_CNT_STEP);
  wire [PBS_LO_W-1:0]   adv_lo   = burst_lo(base_q, cnt_nx, burst_order_select);
  wire                  adv_wr   = (burst_q == PBS_WR_BURST);

  pbs_stage_s new_cmd;
  assign new_cmd.vld  = ld_go || adv_go;
  assign new_cmd.wr   = ld_go ? !read_write : adv_wr;
  assign new_cmd.addr = ld_go ? addr : {hi_q, adv_lo};
  assign new_cmd.bwn  = byte_lane_write_n;

  // Burst tracking; a deselect ends any burst
  wire pbs_burst_e burst_nx = ld_go ? (read_write ? PBS_RD_BURST : PBS_WR_BURST) :
                              desel ? PBS_IDLE : burst_q;
  assign burst_d = en ? burst_nx : burst_q;
  assign base_d  = (en && ld_go) ? addr[PBS_LO_W-1:0] : base_q;
  assign hi_d    = (en && ld_go) ? addr[PBS_AW-1:PBS_LO_W] : hi_q;
  assign cnt_d   = !en   ? cnt_q :
                   ld_go ? PBS_CNT_START :
                   adv_go ? cnt_nx : cnt_q;

  // ************************************************************
  // Two-stage pipeline
  // ************************************************************
  assign s1_d = en ? (new_cmd.vld ? new_cmd : PBS_STAGE_IDLE) : s1_q;
  assign s2_d = en ? s1_q : s2_q;

  // Write commits when its data is on the bus, two cycles after the command
  wire mem_we = en && s2_q.vld && s2_q.wr;
  wire [PBS_DW-1:0] mem_old = mem_q[s2_q.addr];
  wire [PBS_DW-1:0] mem_new = lane_merge(mem_old, dq_in, s2_q.bwn);

  // Read fetch with forwarding from the write committing on the same edge
  wire [PBS_DW-1:0] rd_raw  = mem_q[s1_q.addr];
  wire              fwd_hit = s2_q.vld && s2_q.wr && (s2_q.addr == s1_q.addr);
  wire [PBS_DW-1:0] rd_word = fwd_hit ? lane_merge(rd_raw, dq_in, s2_q.bwn) : rd_raw;
  wire              rd_due  = s1_q.vld && !s1_q.wr;

  assign dq_out_d = (en && rd_due) ? rd_word : dq_out_q;
  assign dq_oe_d  = en ? (rd_due && !out_drive_n) : dq_oe_q;

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_q  <= PBS_IDLE;
      base_q   <= PBS_CNT_START;
      cnt_q    <= PBS_CNT_START;
      hi_q     <= '0;
      s1_q     <= PBS_STAGE_IDLE;
      s2_q     <= PBS_STAGE_IDLE;
      dq_out_q <= PBS_DQ_RESET;
      dq_oe_q  <= 1'b0;
    end else begin
      burst_q  <= burst_d;
      base_q   <= base_d;
      cnt_q    <= cnt_d;
      hi_q     <= hi_d;
      s1_q     <= s1_d;
      s2_q     <= s2_d;
      dq_out_q <= dq_out_d;
      dq_oe_q  <= dq_oe_d;
    end
  end

  // Array storage, not reset
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      mem_q[s2_q.addr] <= mem_new;
    end
  end

  assign dq_out = dq_out_q;
  assign dq_oe  = dq_oe_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence seq_read_load;
    en && ld_go && read_write;
  endsequence

  sequence seq_drive_ok;
    en && !out_drive_n;
  endsequence

  sequence seq_write_load;
    en && ld_go && !read_write;
  endsequence

  sequence seq_advance;
    en && adv_go;
  endsequence

  a_order_interleave: assert property (
    (en && adv_go && burst_order_select) |=>
      s1_q.addr[PBS_LO_W-1:0] == ($past(base_q) ^ PBS_LO_W'($past(cnt_q) + PBS_CNT_STEP)))
    else $error("interleaved burst address wrong");

  a_order_linear: assert property (
    (en && adv_go && !burst_order_select) |=>
      s1_q.addr[PBS_LO_W-1:0] == PBS_LO_W'($past(base_q) + $past(cnt_q) + PBS_CNT_STEP))
    else $error("linear burst address wrong");

  a_burst_wraps: assert property (
    (en && adv_go && cnt_q == PBS_CNT_LAST) |=>
      s1_q.vld && s1_q.addr[PBS_LO_W-1:0] == $past(base_q) && cnt_q == PBS_CNT_START)
    else $error("burst counter did not wrap to start");

  a_read_latency: assert property (
    seq_read_load ##1 seq_drive_ok |=> dq_oe_q && dq_out_q == $past(rd_word))
    else $error("read word not driven two cycles after load");

  a_burst_stream: assert property (
    (seq_read_load ##1 (en && advance_or_load && !out_drive_n) [*3]) ##1 seq_drive_ok
      |=> dq_oe_q && $past(dq_oe_q, 1) && $past(dq_oe_q, 2) && $past(dq_oe_q, 3))
    else $error("burst read words not back to back");

  a_gate_holds: assert property (
    !en |=> $stable(dq_out_q) && $stable(dq_oe_q) && $stable(s1_q) && $stable(cnt_q))
    else $error("state changed on a gated edge");

  a_deselect_float: assert property (
    (en && desel) ##1 en |=> !dq_oe_q)
    else $error("bus not floated after deselect");

  a_deselect_stop: assert property (
    (en && desel) |=> burst_q == PBS_IDLE)
    else $error("deselect did not end the burst");

  a_idle_cycle_idle: assert property (
    (en && advance_or_load && burst_q == PBS_IDLE) |=> !s1_q.vld)
    else $error("advance without burst started a transfer");

  a_wr_bus_quiet: assert property (
    seq_write_load ##1 en |=> !dq_oe_q)
    else $error("bus driven in a write data cycle");

  a_select_needed: assert property (
    (en && ld && !sel) |=> !s1_q.vld)
    else $error("load taken while deselected");

  a_dir_fixed: assert property (
    (en && adv_go) |=> s1_q.wr == ($past(burst_q) == PBS_WR_BURST))
    else $error("advance direction differs from loaded burst");

  a_lane_write: assert property (
    (mem_we && !s2_q.bwn[0] && s2_q.bwn[1]) |=>
      mem_q[$past(s2_q.addr)][PBS_LANE_W-1:0] == $past(dq_in[PBS_LANE_W-1:0]) &&
      mem_q[$past(s2_q.addr)][2*PBS_LANE_W-1:PBS_LANE_W] ==
        $past(mem_old[2*PBS_LANE_W-1:PBS_LANE_W]))
    else $error("byte lane write wrong");

  a_drive_only_read: assert property (
    dq_oe_q |-> $past(en && rd_due && !out_drive_n) || $past(!en))
    else $error("bus driven without a due read");

  a_drive_refused: assert property (
    (en && rd_due && out_drive_n) |=> !dq_oe_q)
    else $error("bus driven with output drive disabled");

  // Burst addressing
  a_advance_step: assert property (
    seq_advance |=> s1_q.vld && cnt_q == PBS_LO_W'($past(cnt_q) + PBS_CNT_STEP))
    else $error("advance did not step the counter");

  a_count_load: assert property (
    (en && ld_go) |=> cnt_q == PBS_CNT_START && base_q == $past(addr[PBS_LO_W-1:0]))
    else $error("load did not restart the counter");

  a_hi_hold: assert property (
    seq_advance |=> s1_q.addr[PBS_AW-1:PBS_LO_W] == $past(hi_q))
    else $error("burst upper address changed");

  a_burst_kept: assert property (
    seq_advance |=> burst_q == $past(burst_q))
    else $error("advance changed the burst direction");

  // Pipeline timing
  a_read_load: assert property (
    seq_read_load |=> s1_q.vld && !s1_q.wr && s1_q.addr == $past(addr))
    else $error("read load not taken");

  a_write_load: assert property (
    seq_write_load |=> s1_q.vld && s1_q.wr && s1_q.bwn == $past(byte_lane_write_n))
    else $error("write load not taken");

  a_write_latency: assert property (
    seq_write_load ##1 en |=> s2_q.vld && s2_q.wr && s2_q.addr == $past(addr, 2))
    else $error("write not due two cycles after load");

  a_write_commit: assert property (
    (mem_we && s2_q.bwn == 4'h0) |=> mem_q[$past(s2_q.addr)] == $past(dq_in))
    else $error("write word not stored");

  a_rw_back_to_back: assert property (
    seq_write_load ##1 seq_read_load |=> s1_q.vld && !s1_q.wr && s2_q.vld && s2_q.wr)
    else $error("read after write not pipelined");

  a_stage_shift: assert property (
    en |=> s2_q == $past(s1_q))
    else $error("pipeline stage did not shift");

  a_data_kept: assert property (
    (en && !rd_due) |=> $stable(dq_out_q))
    else $error("read data changed without a read");

  a_sample_edge: assert property (
    !$stable(dq_out_q) |-> $past(en && rd_due))
    else $error("read data changed off a read edge");

  // Gating and lanes
  a_gate_hold_burst: assert property (
    !en |=> $stable(burst_q) && $stable(base_q) && $stable(s2_q) && $stable(hi_q))
    else $error("burst state changed on a gated edge");

  a_lane_upper: assert property (
    (mem_we && !s2_q.bwn[2] && s2_q.bwn[3]) |=>
      mem_q[$past(s2_q.addr)][3*PBS_LANE_W-1:2*PBS_LANE_W] ==
        $past(dq_in[3*PBS_LANE_W-1:2*PBS_LANE_W]) &&
      mem_q[$past(s2_q.addr)][4*PBS_LANE_W-1:3*PBS_LANE_W] ==
        $past(mem_old[4*PBS_LANE_W-1:3*PBS_LANE_W]))
    else $error("upper byte lane write wrong");

endmodule

//--- tb/pbs_host_model.sv
// Purpose: Host side of the shared data bus of the SRAM port
// Assumes: Bench says in which cycle the host drives write data
// Notes:   A bus nobody drives shows the inverse of its last level
module pbs_host_model
  import pbs_pkg::*;
(
  input  wire logic              core_clk,  // Clock
  input  wire logic              wr_en,     // Host drives write data
  input  wire logic [PBS_DW-1:0] wr_data,   // Write data word
  input  wire logic [PBS_DW-1:0] dq_out,    // Device read data
  input  wire logic              dq_oe,     // Device drives bus
  output logic      [PBS_DW-1:0] dq_in,     // Resolved bus level
  output logic                   clash      // Both sides drive
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [PBS_DW-1:0] last_q = '0;

  always_ff @(posedge core_clk) last_q <= dq_in;

  // Stale level would hide a missed sample, so undriven bus flips
  assign dq_in = dq_oe ? dq_out : wr_en ? wr_data : ~last_q;
  assign clash = dq_oe & wr_en;
endmodule

//--- tb/pbs_sram_port_tb_top.sv
// Purpose: Self-checking bench for the pipelined burst SRAM port
// Assumes: Host model resolves the shared data bus
// Notes:   Each scenario drives cycle by cycle and checks the bus
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_fail++; \
  $display("unexpected %s exp=%h got=%h", nm, ex, got); end end
module pbs_sram_port_tb_top
  import pbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [2:0]        LW = 3'h0, LR = 3'h2, AD = 3'h4, GT = 3'h1;
  localparam logic [2:0]        SEL = 3'h2, DES = 3'h6;
  localparam logic [1:0]        NC = 2'h0, Z = 2'h2, Q = 2'h3;
  localparam logic [PBS_DW-1:0] MIX = 36'hf_f803_fe00;
  logic                 core_clk           = 1'b0;
  logic                 rst_n              = 1'b0;
  logic [PBS_AW-1:0]    addr               = '0;
  logic                 read_write         = 1'b1;
  logic                 advance_or_load    = 1'b1;
  logic                 clock_gate_n       = 1'b0;
  logic [PBS_LANES-1:0] byte_lane_write_n  = 4'hf;
  logic                 chip_select_a_n    = 1'b1;
  logic                 chip_select_b      = 1'b0;
  logic                 chip_select_c_n    = 1'b1;
  logic                 burst_order_select = 1'b0;
  logic                 out_drive_n        = 1'b0;
  logic                 wr_en              = 1'b0;
  logic [PBS_DW-1:0]    wr_data            = '0;
  logic [PBS_DW-1:0]    dq_in;
  logic [PBS_DW-1:0]    dq_out;
  logic                 dq_oe;
  logic                 clash;
  logic                 ord_nxt            = 1'b0;
  logic                 odn_nxt            = 1'b0;
  int                   n_fail             = 0;
  int                   checked            = 0;
  logic [PBS_DW-1:0]    dw [4]             = '{36'h1_2345_6789, 36'h9_8765_4321,
                                               36'hf_0f0f_0f0f, 36'h0_f0f0_f0f0};

  pbs_sram_port i_dut (.core_clk, .rst_n, .addr, .read_write, .advance_or_load,
    .clock_gate_n, .byte_lane_write_n, .chip_select_a_n, .chip_select_b,
    .chip_select_c_n, .burst_order_select, .out_drive_n, .dq_in, .dq_out, .dq_oe);
  pbs_host_model i_host (.core_clk, .wr_en, .wr_data, .dq_out, .dq_oe, .dq_in, .clash);

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  // ************************************************************
  // Cycle driver and scenarios
  // ************************************************************
  task automatic cyc(input logic [2:0] c, cs, input logic [PBS_AW-1:0] a,
    input logic [3:0] bw, input logic w, input logic [PBS_DW-1:0] wd,
    input logic [1:0] e, input logic [PBS_DW-1:0] ed);
    @(posedge core_clk);
    #1;
    {advance_or_load, read_write, clock_gate_n} = c;
    {chip_select_a_n, chip_select_b, chip_select_c_n} = cs;
    addr = a;
    byte_lane_write_n = bw;
    wr_en = w;
    wr_data = wd;
    burst_order_select = ord_nxt;
    out_drive_n = odn_nxt;
    #1;
    if (e[1]) `CHK("oe", e[0], dq_oe)
    if (e == Q) `CHK("rd", ed, dq_out)
    `CHK("clash", 1'b0, clash)
  endtask

  task automatic burst_mix;
    ord_nxt = 1'b0;
    cyc(LW, SEL, 17'h0_0101, 4'h0, 1'b0, '0, Z, '0);
    cyc(AD, DES, '1, 4'h0, 1'b0, '0, Z, '0);
    cyc(AD, DES, '1, 4'h0, 1'b1, dw[0], Z, '0);
    cyc(AD, DES, '1, 4'h0, 1'b1, dw[1], Z, '0);
    ord_nxt = 1'b1;
    cyc(LR, SEL, 17'h0_0103, 4'h0, 1'b1, dw[2], Z, '0);
    cyc(AD, DES, '1, 4'hf, 1'b1, dw[3], Z, '0);
    cyc(AD, DES, '1, 4'hf, 1'b0, '0, Q, dw[2]);
    cyc(AD, DES, '1, 4'hf, 1'b0, '0, Q, dw[1]);
    cyc(AD, DES, '1, 4'hf, 1'b0, '0, Q, dw[0]);
    cyc(LR, SEL, 17'h0_0101, 4'hf, 1'b0, '0, Q, dw[3]);
    cyc(LW, DES, '1, 4'hf, 1'b0, '0, Q, dw[2]);
    cyc(AD, DES, '1, 4'hf, 1'b0, '0, Q, dw[0]);
    cyc(AD, DES, '1, 4'hf, 1'b0, '0, Z, '0);
  endtask

  task automatic lanes_gate;
    ord_nxt = 1'b0;
    cyc(LW, SEL, 17'h0_0200, 4'h0, 1'b0, '0, Z, '0);
    cyc(LW, SEL, 17'h0_0200, 4'ha, 1'b0, '0, Z, '0);
    cyc(LW, DES, '1, 4'hf, 1'b1, 36'hf_ffff_ffff, Z, '0);
    cyc(AD, DES, '1, 4'hf, 1'b1, '0, Z, '0);
    cyc(LR, SEL, 17'h0_0200, 4'hf, 1'b0, '0, Z, '0);
    cyc(GT, SEL, '1, 4'hf, 1'b0, '0, Z, '0);
    cyc(LW, DES, '1, 4'hf, 1'b0, '0, Z, '0);
    cyc(GT, DES, '1, 4'hf, 1'b0, '0, Q, MIX);
    cyc(LW, DES, '1, 4'hf, 1'b0, '0, Q, MIX);
    cyc(LR, SEL, 17'h0_0200, 4'hf, 1'b0, '0, Z, '0);
    odn_nxt = 1'b1;
    cyc(LW, DES, '1, 4'hf, 1'b0, '0, Z, '0);
    odn_nxt = 1'b0;
    cyc(LW, DES, '1, 4'hf, 1'b0, '0, Z, '0);
    cyc(LW, DES, '1, 4'hf, 1'b0, '0, Z, '0);
  endtask

  task automatic selects;
    logic [2:0] pat [4] = '{3'h6, 3'h0, 3'h3, SEL};
    for (int i = 0; i < 4; i++) begin
      cyc(LR, pat[i], 17'h0_0200, 4'hf, 1'b0, '0, NC, '0);
      cyc(LW, DES, '1, 4'hf, 1'b0, '0, NC, '0);
      cyc(LW, DES, '1, 4'hf, 1'b0, '0, {1'b1, pat[i] == SEL}, MIX);
    end
  endtask

  task automatic turnaround;
    ord_nxt = 1'b0;
    cyc(LW, SEL, 17'h0_0300, 4'h0, 1'b0, '0, Z, '0);
    cyc(LR, SEL, 17'h0_0300, 4'hf, 1'b0, '0, Z, '0);
    cyc(LW, SEL, 17'h0_0301, 4'h0, 1'b1, dw[1], Z, '0);
    cyc(LR, SEL, 17'h0_0301, 4'hf, 1'b0, '0, Q, dw[1]);
    cyc(LW, DES, '1, 4'hf, 1'b1, dw[2], Z, '0);
    cyc(LW, DES, '1, 4'hf, 1'b0, '0, Q, dw[2]);
    cyc(LW, DES, '1, 4'hf, 1'b0, '0, Z, '0);
  endtask

  task automatic finish_test;
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    #1;
    `CHK("oe", 1'b0, dq_oe)
    rst_n = 1'b1;
    burst_mix();
    lanes_gate();
    selects();
    turnaround();
    finish_test();
  end

  initial begin
    repeat (500) @(posedge core_clk);
    n_fail++;
    finish_test();
  end
endmodule
